/* src/wcm_pkg.sv */
package wcm_pkg;

// ==========================================
// Window and bus geometry
localparam int NWIN = 8;
localparam logic [2:0] WIN_MAX = 3'h7;
localparam logic [2:0] WIN_NM2 = 3'h6;
localparam logic [2:0] SIZE_WORD = 3'h2;
localparam int ADDR_TOP = 31;
localparam int ADDR_IDX_HI = 5;
localparam int ADDR_IDX_LO = 2;

// ==========================================
// Register word indices (byte address = 4 * index)
localparam logic [3:0] IDX_CTRL = 4'h0;
localparam logic [3:0] IDX_WIN = 4'h1;
localparam logic [3:0] IDX_CC = 4'h2;
localparam logic [3:0] IDX_FSR = 4'h3;
localparam logic [3:0] IDX_OPA = 4'h4;
localparam logic [3:0] IDX_OPB = 4'h5;
localparam logic [3:0] IDX_CMD = 4'h6;
localparam logic [3:0] IDX_RESULT = 4'h7;
localparam logic [3:0] IDX_STATUS = 4'h8;

// ==========================================
// Field positions
localparam int CTRL_FPU = 0;
localparam int CTRL_PEF = 1;
localparam int CTRL_FEF = 2;
localparam int CTRL_PRIV = 3;
localparam int WIN_CWP = 0;
localparam int WIN_CSV = 4;
localparam int WIN_CRS = 8;
localparam int WIN_CLN = 12;
localparam int WIN_OTH = 16;
localparam int CC_ICC = 0;
localparam int CC_XCC = 4;
localparam int FSR_CEXC = 0;
localparam int FSR_AEXC = 5;
localparam int FSR_FTT = 14;
localparam int FSR_FCC = 24;
localparam int CMD_OP = 0;
localparam int CMD_COND = 5;
localparam int CMD_CCSEL = 9;
localparam int CMD_RCOND = 12;
localparam int CMD_FPDST = 15;
localparam int CMD_FCCSEL = 16;
localparam int CMD_IEEE = 18;
localparam int CMD_ASR = 23;
localparam int CMD_ASSIGNED = 28;
localparam int ST_EXC = 0;
localparam int ST_MOVED = 3;

// ==========================================
// Encodings
localparam logic [4:0] ASR_PRIV_FIRST = 5'h10;
localparam logic [2:0] FTT_NONE = 3'h0;
localparam logic [2:0] incomplete_float_op_code = 3'h2;
localparam logic [2:0] CC_SEL_ICC = 3'h0;
localparam logic [2:0] CC_SEL_XCC = 3'h1;
localparam logic [2:0] CC_SEL_FCC3 = 3'h5;
localparam logic [1:0] FCC_EQ = 2'h0;
localparam logic [1:0] FCC_LT = 2'h1;
localparam logic [1:0] FCC_GT = 2'h2;
localparam logic [3:0] COND_G = 4'h6;
// One nibble per condition, bit k set when fcc value k satisfies it
localparam logic [63:0] FCC_TRUE_MAP = 64'h7b3d591f84c2a6e0;

typedef enum logic [4:0] {
	OP_INT_COND_CODE_MOVE = 5'h00, OP_INT_REG_COND_MOVE = 5'h01, OP_SAVE = 5'h02, OP_RESTORE = 5'h03,
	OP_SAVED = 5'h04, OP_RESTORED = 5'h05, OP_FLUSH_WINDOWS_INSTR = 5'h06, OP_RDASR = 5'h07,
	OP_WRASR = 5'h08, OP_RDPR = 5'h09, OP_WRPR = 5'h0a, OP_FCMP = 5'h0b,
	OP_FP_OPERATE_INSTR = 5'h0c, OP_FMOV = 5'h0d, OP_FUNF = 5'h0e, OP_IMPDEP = 5'h0f
} wcm_op_t;

typedef enum logic [2:0] {
	EXC_NONE = 3'h0, EXC_SPILL = 3'h1, EXC_FILL = 3'h2, EXC_CLEAN = 3'h3,
	EXC_FPU_OFF = 3'h4, EXC_OTHER_FLOAT = 3'h5, EXC_PRIV = 3'h6, EXC_ILLEGAL = 3'h7
} wcm_exc_t;

typedef struct packed {
	logic ap_valid;
	logic ap_write;
	logic [3:0] ap_idx;
	logic fpu_present;
	logic proc_state_fpu_enable;
	logic fp_reg_status_enable;
	logic priv;
	logic [2:0] current_window_pointer;
	logic [2:0] saveable_window_count;
	logic [2:0] restorable_window_count;
	logic [2:0] clean_window_count;
	logic [2:0] other_window_count;
	logic [3:0] icc;
	logic [3:0] xcc;
	logic [7:0] fcc;
	logic [2:0] ftt;
	logic [4:0] aexc;
	logic [4:0] cexc;
	logic [31:0] opa;
	logic [31:0] opb;
	logic [31:0] result;
	logic [31:0] asr_val;
	logic [31:0] pr_val;
	logic [31:0] rdata;
	wcm_exc_t exc;
	logic moved;
} wcm_state_t;

endpackage : wcm_pkg

/* src/wcm_exec.sv */
`timescale 1ns/1ps
module wcm_exec
	import wcm_pkg::*;
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Status
	output logic [2:0] exc_code
);

// ==========================================
// Condition decoding
function automatic logic int_cond_ok(input logic [3:0] cond, input logic [3:0] f);
	logic b;
	b = 1'b0;
	case (cond[2:0])
		3'h0: b = 1'b0;
		3'h1: b = f[2];
		3'h2: b = f[2] | (f[3] ^ f[1]);
		3'h3: b = f[3] ^ f[1];
		3'h4: b = f[0] | f[2];
		3'h5: b = f[0];
		3'h6: b = f[3];
		default: b = f[1];
	endcase
	return b ^ cond[3];
endfunction : int_cond_ok

function automatic logic fcc_cond_ok(input logic [3:0] cond, input logic [1:0] v);
	logic [3:0] m;
	m = FCC_TRUE_MAP[{cond, 2'h0} +: 4];
	return m[v];
endfunction : fcc_cond_ok

function automatic logic rcond_ok(input logic [2:0] rc, input logic [31:0] v);
	logic z;
	z = (v == 32'h0);
	case (rc)
		3'h1: return z;
		3'h2: return v[31] | z;
		3'h3: return v[31];
		3'h5: return !z;
		3'h6: return !v[31] && !z;
		default: return !v[31];
	endcase
endfunction : rcond_ok

function automatic logic [31:0] rd_word(input wcm_state_t st, input logic [3:0] idx);
	logic [31:0] w;
	w = 32'h0;
	case (idx)
		IDX_CTRL: begin
			w[CTRL_FPU] = st.fpu_present;
			w[CTRL_PEF] = st.proc_state_fpu_enable;
			w[CTRL_FEF] = st.fp_reg_status_enable;
			w[CTRL_PRIV] = st.priv;
		end
		IDX_WIN: begin
			w[WIN_CWP +: 3] = st.current_window_pointer;
			w[WIN_CSV +: 3] = st.saveable_window_count;
			w[WIN_CRS +: 3] = st.restorable_window_count;
			w[WIN_CLN +: 3] = st.clean_window_count;
			w[WIN_OTH +: 3] = st.other_window_count;
		end
		IDX_CC: begin
			w[CC_ICC +: 4] = st.icc;
			w[CC_XCC +: 4] = st.xcc;
		end
		IDX_FSR: begin
			w[FSR_CEXC +: 5] = st.cexc;
			w[FSR_AEXC +: 5] = st.aexc;
			w[FSR_FTT +: 3] = st.ftt;
			w[FSR_FCC +: 8] = st.fcc;
		end
		IDX_OPA: w = st.opa;
		IDX_OPB: w = st.opb;
		IDX_RESULT: w = st.result;
		IDX_STATUS: begin
			w[ST_EXC +: 3] = st.exc;
			w[ST_MOVED] = st.moved;
		end
		default: w = 32'h0;
	endcase
	return w;
endfunction : rd_word

// ==========================================
// State
wcm_state_t s_reg;
wcm_state_t s_next;
logic exec;
wcm_op_t ex_op;

assign exec = s_reg.ap_valid && s_reg.ap_write && (s_reg.ap_idx == IDX_CMD);
assign ex_op = wcm_op_t'(hwdata[CMD_OP +: 5]);
assign hreadyout = 1'b1;
assign hresp = 1'b0;
assign hrdata = s_reg.rdata;
assign exc_code = s_reg.exc;

// ==========================================
// Next state
always_comb begin
	logic [3:0] cond;
	logic [2:0] ccsel;
	logic [1:0] fs;
	logic [4:0] ieee;
	logic fpacc;
	logic ok;
	logic [2:0] clean_avail;
	logic [2:0] valid_win;
	cond = hwdata[CMD_COND +: 4];
	ccsel = hwdata[CMD_CCSEL +: 3];
	fs = hwdata[CMD_FCCSEL +: 2];
	ieee = hwdata[CMD_IEEE +: 5];
	ok = 1'b0;
	clean_avail = 3'(s_reg.clean_window_count - s_reg.restorable_window_count);
	valid_win = 3'(WIN_NM2 - s_reg.saveable_window_count);
	fpacc = (ex_op == OP_FCMP) || (ex_op == OP_FP_OPERATE_INSTR) || (ex_op == OP_FMOV)
		|| (ex_op == OP_FUNF) || ((ex_op == OP_IMPDEP) && hwdata[CMD_ASSIGNED])
		|| (((ex_op == OP_INT_COND_CODE_MOVE) || (ex_op == OP_INT_REG_COND_MOVE)) && hwdata[CMD_FPDST]);
	s_next = s_reg;
	if (s_reg.ap_valid && s_reg.ap_write) begin
		case (s_reg.ap_idx)
			IDX_CTRL: begin
				s_next.fpu_present = hwdata[CTRL_FPU];
				s_next.proc_state_fpu_enable = hwdata[CTRL_PEF];
				s_next.fp_reg_status_enable = hwdata[CTRL_FEF];
				s_next.priv = hwdata[CTRL_PRIV];
			end
			IDX_WIN: begin
				s_next.current_window_pointer = hwdata[WIN_CWP +: 3];
				s_next.saveable_window_count = hwdata[WIN_CSV +: 3];
				s_next.restorable_window_count = hwdata[WIN_CRS +: 3];
				s_next.clean_window_count = hwdata[WIN_CLN +: 3];
				s_next.other_window_count = hwdata[WIN_OTH +: 3];
			end
			IDX_CC: begin
				s_next.icc = hwdata[CC_ICC +: 4];
				s_next.xcc = hwdata[CC_XCC +: 4];
			end
			IDX_FSR: begin
				s_next.cexc = hwdata[FSR_CEXC +: 5];
				s_next.aexc = hwdata[FSR_AEXC +: 5];
				s_next.ftt = hwdata[FSR_FTT +: 3];
				s_next.fcc = hwdata[FSR_FCC +: 8];
			end
			IDX_OPA: s_next.opa = hwdata;
			IDX_OPB: s_next.opb = hwdata;
			default: begin
			end
		endcase
	end
	if (exec) begin
		s_next.exc = EXC_NONE;
		s_next.moved = 1'b0;
		if (fpacc && !(s_reg.fpu_present && s_reg.proc_state_fpu_enable
				&& s_reg.fp_reg_status_enable)) begin
			s_next.exc = EXC_FPU_OFF;
		end else begin
			case (ex_op)
				OP_INT_COND_CODE_MOVE: begin
					if (ccsel == CC_SEL_ICC) begin
						ok = int_cond_ok(cond, s_reg.icc);
					end else if (ccsel == CC_SEL_XCC) begin
						ok = int_cond_ok(cond, s_reg.xcc);
					end else if (ccsel <= CC_SEL_FCC3) begin
						ok = fcc_cond_ok(cond, s_reg.fcc[{2'(ccsel - 3'h2), 1'b0} +: 2]);
					end else begin
						s_next.exc = EXC_ILLEGAL;
					end
					if (ok) begin
						s_next.result = s_reg.opb;
						s_next.moved = 1'b1;
					end
					if (hwdata[CMD_FPDST]) begin
						s_next.ftt = FTT_NONE;
						s_next.cexc = 5'h0;
					end
				end
				OP_INT_REG_COND_MOVE: begin
					if (hwdata[CMD_RCOND +: 2] == 2'h0) begin
						s_next.exc = EXC_ILLEGAL;
					end else if (rcond_ok(hwdata[CMD_RCOND +: 3], s_reg.opa)) begin
						s_next.result = s_reg.opb;
						s_next.moved = 1'b1;
					end
					if (hwdata[CMD_FPDST] && (hwdata[CMD_RCOND +: 2] != 2'h0)) begin
						s_next.ftt = FTT_NONE;
						s_next.cexc = 5'h0;
					end
				end
				OP_SAVE: begin
					if (s_reg.saveable_window_count == 3'h0) begin
						s_next.exc = EXC_SPILL;
					end else if (clean_avail == 3'h0) begin
						s_next.exc = EXC_CLEAN;
					end else begin
						s_next.current_window_pointer = 3'(s_reg.current_window_pointer + 3'h1);
						s_next.result = s_reg.opa + s_reg.opb;
						s_next.saveable_window_count = 3'(s_reg.saveable_window_count - 3'h1);
						s_next.restorable_window_count =
							3'(s_reg.restorable_window_count + 3'h1);
					end
				end
				OP_RESTORE: begin
					if (s_reg.restorable_window_count == 3'h0) begin
						s_next.exc = EXC_FILL;
					end else begin
						s_next.current_window_pointer = 3'(s_reg.current_window_pointer - 3'h1);
						s_next.result = s_reg.opa + s_reg.opb;
						s_next.restorable_window_count =
							3'(s_reg.restorable_window_count - 3'h1);
						s_next.saveable_window_count = 3'(s_reg.saveable_window_count + 3'h1);
					end
				end
				OP_SAVED: begin
					if (!s_reg.priv) begin
						s_next.exc = EXC_PRIV;
					end else begin
						s_next.saveable_window_count = 3'(s_reg.saveable_window_count + 3'h1);
						if (s_reg.other_window_count != 3'h0) begin
							s_next.other_window_count = 3'(s_reg.other_window_count - 3'h1);
						end else begin
							s_next.restorable_window_count =
								3'(s_reg.restorable_window_count - 3'h1);
						end
					end
				end
				OP_RESTORED: begin
					if (!s_reg.priv) begin
						s_next.exc = EXC_PRIV;
					end else begin
						s_next.restorable_window_count =
							3'(s_reg.restorable_window_count + 3'h1);
						if (s_reg.other_window_count != 3'h0) begin
							s_next.other_window_count = 3'(s_reg.other_window_count - 3'h1);
						end else begin
							s_next.saveable_window_count = 3'(s_reg.saveable_window_count - 3'h1);
						end
						if (s_reg.clean_window_count != WIN_MAX) begin
							s_next.clean_window_count = 3'(s_reg.clean_window_count + 3'h1);
						end
					end
				end
				OP_FLUSH_WINDOWS_INSTR: begin
					if (valid_win != 3'h0) begin
						s_next.exc = EXC_SPILL;
					end
				end
				OP_RDASR, OP_WRASR: begin
					if (!s_reg.priv && (hwdata[CMD_ASR +: 5] >= ASR_PRIV_FIRST)) begin
						s_next.exc = EXC_PRIV;
					end else if (ex_op == OP_RDASR) begin
						s_next.result = s_reg.asr_val;
					end else begin
						s_next.asr_val = s_reg.opa;
					end
				end
				OP_RDPR, OP_WRPR: begin
					if (!s_reg.priv) begin
						s_next.exc = EXC_PRIV;
					end else if (ex_op == OP_RDPR) begin
						s_next.result = s_reg.pr_val;
					end else begin
						s_next.pr_val = s_reg.opa;
					end
				end
				OP_FCMP: begin
					if (s_reg.opa == s_reg.opb) begin
						s_next.fcc[{fs, 1'b0} +: 2] = FCC_EQ;
					end else if ($signed(s_reg.opa) < $signed(s_reg.opb)) begin
						s_next.fcc[{fs, 1'b0} +: 2] = FCC_LT;
					end else begin
						s_next.fcc[{fs, 1'b0} +: 2] = FCC_GT;
					end
					s_next.ftt = FTT_NONE;
					s_next.cexc = ieee;
					s_next.aexc = s_reg.aexc | ieee;
				end
				OP_FP_OPERATE_INSTR: begin
					s_next.result = s_reg.opa;
					s_next.ftt = FTT_NONE;
					s_next.cexc = ieee;
					s_next.aexc = s_reg.aexc | ieee;
				end
				OP_FMOV: begin
					s_next.result = s_reg.opa;
					s_next.ftt = FTT_NONE;
					s_next.cexc = 5'h0;
				end
				OP_FUNF: begin
					s_next.exc = EXC_OTHER_FLOAT;
					s_next.ftt = incomplete_float_op_code;
				end
				OP_IMPDEP: begin
					if (!hwdata[CMD_ASSIGNED]) begin
						s_next.exc = EXC_ILLEGAL;
					end else begin
						s_next.result = s_reg.opa;
						s_next.ftt = FTT_NONE;
						s_next.cexc = ieee;
						s_next.aexc = s_reg.aexc | ieee;
					end
				end
				default: s_next.exc = EXC_ILLEGAL;
			endcase
		end
	end
	s_next.ap_valid = hsel && hready && htrans[1] && (hsize == SIZE_WORD)
		&& (haddr[ADDR_TOP:ADDR_IDX_HI + 1] == '0);
	s_next.ap_write = hwrite;
	s_next.ap_idx = haddr[ADDR_IDX_HI:ADDR_IDX_LO];
	if (s_next.ap_valid && !hwrite) begin
		s_next.rdata = rd_word(s_next, s_next.ap_idx);
	end
end

always_ff @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		s_reg <= '0;
		s_reg.saveable_window_count <= WIN_NM2;
		s_reg.clean_window_count <= WIN_MAX;
	end else begin
		s_reg <= s_next;
	end
end

// ==========================================
// Assertions
default clocking cb @(posedge hclk); endclocking
default disable iff (!hresetn);

a_save_spill: assert property (exec && ex_op == OP_SAVE
	&& s_reg.saveable_window_count == 3'h0
	|=> s_reg.exc == EXC_SPILL && $stable(s_reg.current_window_pointer))
	else $error("save with no saveable window did not spill");
a_save_clean: assert property (exec && ex_op == OP_SAVE
	&& s_reg.saveable_window_count != 3'h0
	&& 3'(s_reg.clean_window_count - s_reg.restorable_window_count) == 3'h0
	|=> s_reg.exc == EXC_CLEAN && $stable(s_reg.saveable_window_count))
	else $error("save without clean window did not trap");
a_save_adv: assert property (exec && ex_op == OP_SAVE && s_reg.exc == EXC_NONE
	##1 s_reg.exc == EXC_NONE |-> s_reg.current_window_pointer
	== 3'($past(s_reg.current_window_pointer) + 3'h1)
	&& s_reg.result == $past(s_reg.opa) + $past(s_reg.opb))
	else $error("save did not advance window and add");
a_restore_fill: assert property (exec && ex_op == OP_RESTORE
	&& s_reg.restorable_window_count == 3'h0 |=> s_reg.exc == EXC_FILL)
	else $error("restore with no restorable window did not fill");
a_flush_spill: assert property (exec && ex_op == OP_FLUSH_WINDOWS_INSTR
	|=> (s_reg.exc == EXC_SPILL) == ($past(s_reg.saveable_window_count) != WIN_NM2))
	else $error("flush spill decision wrong");
a_fpu_off: assert property (exec && ex_op == OP_FP_OPERATE_INSTR && !s_reg.fp_reg_status_enable
	|=> s_reg.exc == EXC_FPU_OFF && $stable(s_reg.cexc))
	else $error("disabled FPU did not trap");
a_mov_hold: assert property (exec && ex_op == OP_INT_COND_CODE_MOVE && !hwdata[CMD_FPDST]
	&& hwdata[CMD_CCSEL +: 3] == 3'h4 && hwdata[CMD_COND +: 4] == COND_G
	&& s_reg.fcc[5:4] != FCC_GT |=> !s_reg.moved && $stable(s_reg.result))
	else $error("false condition changed destination");
a_saved_cnt: assert property (exec && ex_op == OP_SAVED && s_reg.priv
	&& s_reg.other_window_count != 3'h0 |=> $stable(s_reg.restorable_window_count)
	&& s_reg.other_window_count == 3'($past(s_reg.other_window_count) - 3'h1))
	else $error("spill complete did not prefer other windows");
a_fmov_aexc: assert property (exec && ex_op == OP_FMOV && s_reg.exc == EXC_NONE
	##1 s_reg.exc == EXC_NONE |-> $stable(s_reg.aexc) && s_reg.cexc == 5'h0)
	else $error("move-like float op touched accrued field");
a_priv_trap: assert property (exec && ex_op == OP_WRPR && !s_reg.priv
	|=> s_reg.exc == EXC_PRIV && $stable(s_reg.pr_val))
	else $error("unprivileged register write not trapped");

c_save_ok: cover property (exec && ex_op == OP_SAVE ##1 s_reg.exc == EXC_NONE);
c_spill: cover property (exec && ex_op == OP_FLUSH_WINDOWS_INSTR ##1 s_reg.exc == EXC_SPILL);
c_moved: cover property (exec && ex_op == OP_INT_COND_CODE_MOVE ##1 s_reg.moved);
c_fcmp: cover property (exec && ex_op == OP_FCMP ##1 s_reg.exc == EXC_NONE);

endmodule : wcm_exec

/* verification/wcm_exec_test.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin num_errors++; \
	$display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module wcm_exec_test;
import wcm_pkg::*;
logic hclk = 1'b0;
logic hresetn = 1'b0;
logic hsel = 1'b0;
logic [31:0] haddr = 32'h0;
logic [1:0] htrans = 2'h0;
logic hwrite = 1'b0;
logic [2:0] hsize = 3'h0;
logic [31:0] hwdata = 32'h0;
logic hready;
logic hreadyout;
logic hresp;
logic [31:0] hrdata;
logic [2:0] exc_code;
int num_errors = 0;
int num_checks = 0;
assign hready = hreadyout;
always #4 hclk = ~hclk;
wcm_exec wcm_exec_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .exc_code(exc_code));
// ==========================================
// Bus access
function automatic logic [31:0] ad(logic [3:0] i);
	return {26'h0, i, 2'h0};
endfunction : ad
task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] r);
	@(posedge hclk);
	hsel <= 1'b1;
	htrans <= 2'h2;
	haddr <= a;
	hwrite <= w;
	hsize <= SIZE_WORD;
	do @(posedge hclk); while (hreadyout !== 1'b1);
	htrans <= 2'h0;
	hsel <= 1'b0;
	hwdata <= d;
	do @(posedge hclk); while (hreadyout !== 1'b1);
	r = hrdata;
endtask : bus
task automatic wr(input logic [3:0] i, input logic [31:0] d);
	logic [31:0] r;
	bus(1'b1, ad(i), d, r);
endtask : wr
task automatic rc(input logic [3:0] i, input logic [31:0] e);
	logic [31:0] r;
	bus(1'b0, ad(i), 32'h0, r);
	`CHK(r, e)
endtask : rc
// Runs one command and checks the exception seen in status and on the port
task automatic ex(input logic [31:0] c, input logic [2:0] e);
	logic [31:0] r;
	wr(IDX_CMD, c);
	bus(1'b0, ad(IDX_STATUS), 32'h0, r);
	`CHK(r[2:0], e)
	`CHK(exc_code, e)
endtask : ex
// ==========================================
// Scenarios
task automatic t_reset;
	rc(IDX_WIN, 32'h7060);
	rc(IDX_CTRL, 32'h0);
	rc(IDX_FSR, 32'h0);
	rc(4'hf, 32'h0);
	`CHK(hresp, 1'b0)
	`CHK(exc_code, 3'h0)
	$display("test reset done");
endtask : t_reset
task automatic t_window;
	ex(32'h2, EXC_NONE);
	rc(IDX_WIN, 32'h7151);
	ex(32'h3, EXC_NONE);
	rc(IDX_WIN, 32'h7060);
	ex(32'h3, EXC_FILL);
	rc(IDX_WIN, 32'h7060);
	wr(IDX_WIN, 32'h7000);
	ex(32'h2, EXC_SPILL);
	wr(IDX_WIN, 32'h2230);
	ex(32'h2, EXC_CLEAN);
	rc(IDX_WIN, 32'h2230);
	$display("test window done");
endtask : t_window
task automatic t_flush;
	wr(IDX_WIN, 32'h7060);
	ex(32'h6, EXC_NONE);
	wr(IDX_WIN, 32'h7050);
	ex(32'h6, EXC_SPILL);
	ex(32'h6, EXC_SPILL);
	rc(IDX_WIN, 32'h7050);
	$display("test flush done");
endtask : t_flush
task automatic t_complete;
	wr(IDX_CTRL, 32'h0);
	wr(IDX_WIN, 32'h13220);
	ex(32'h4, EXC_PRIV);
	wr(IDX_CTRL, 32'h8);
	ex(32'h4, EXC_NONE);
	rc(IDX_WIN, 32'h03230);
	ex(32'h4, EXC_NONE);
	rc(IDX_WIN, 32'h03140);
	ex(32'h5, EXC_NONE);
	rc(IDX_WIN, 32'h04230);
	$display("test complete done");
endtask : t_complete
task automatic t_fpu;
	int i;
	wr(IDX_CTRL, 32'h7);
	wr(IDX_FSR, 32'h0);
	wr(IDX_OPA, 32'h11);
	wr(IDX_OPB, 32'h22);
	ex(32'hd000b, EXC_NONE);
	rc(IDX_FSR, 32'h04000063);
	ex(32'he, EXC_OTHER_FLOAT);
	rc(IDX_FSR, 32'h04008063);
	ex(32'h10000c, EXC_NONE);
	rc(IDX_FSR, 32'h040000e4);
	rc(IDX_RESULT, 32'h11);
	ex(32'hd, EXC_NONE);
	rc(IDX_FSR, 32'h040000e0);
	for (i = 0; i < 3; i++) begin
		wr(IDX_CTRL, 32'h7 ^ (32'h1 << i));
		ex(32'hd000b, EXC_FPU_OFF);
		ex(32'hc, EXC_FPU_OFF);
	end
	rc(IDX_FSR, 32'h040000e0);
	$display("test fpu done");
endtask : t_fpu
task automatic t_move;
	wr(IDX_FSR, 32'h20000000);
	wr(IDX_OPB, 32'h5a);
	ex(32'h8c0, EXC_NONE);
	rc(IDX_STATUS, 32'h8);
	rc(IDX_RESULT, 32'h5a);
	wr(IDX_FSR, 32'h10000000);
	wr(IDX_OPB, 32'h77);
	ex(32'h8c0, EXC_NONE);
	rc(IDX_STATUS, 32'h0);
	rc(IDX_RESULT, 32'h5a);
	ex(32'hcc0, EXC_ILLEGAL);
	wr(IDX_OPA, 32'h80000005);
	wr(IDX_OPB, 32'h80000005);
	ex(32'h6001, EXC_NONE);
	rc(IDX_RESULT, 32'h5a);
	ex(32'h3001, EXC_NONE);
	rc(IDX_RESULT, 32'h80000005);
	wr(IDX_OPB, 32'h66);
	wr(IDX_CC, 32'h40);
	ex(32'h220, EXC_NONE);
	rc(IDX_RESULT, 32'h66);
	ex(32'h20, EXC_NONE);
	rc(IDX_STATUS, 32'h0);
	ex(32'h4001, EXC_ILLEGAL);
	$display("test move done");
endtask : t_move
task automatic t_priv;
	wr(IDX_CTRL, 32'h0);
	ex(32'h2800008, EXC_NONE);
	ex(32'h8000008, EXC_PRIV);
	ex(32'h9, EXC_PRIV);
	ex(32'ha, EXC_PRIV);
	wr(IDX_CTRL, 32'hf);
	ex(32'h9, EXC_NONE);
	rc(IDX_RESULT, 32'h0);
	ex(32'ha, EXC_NONE);
	ex(32'h9, EXC_NONE);
	rc(IDX_RESULT, 32'h80000005);
	ex(32'hf, EXC_ILLEGAL);
	wr(IDX_OPA, 32'h3c);
	ex(32'h1000000f, EXC_NONE);
	rc(IDX_RESULT, 32'h3c);
	ex(32'h10, EXC_ILLEGAL);
	rc(4'hf, 32'h0);
	$display("test priv done");
endtask : t_priv
// ==========================================
// Verdict
task automatic print_verdict;
	$display("checks %0d errors %0d", num_checks, num_errors);
	if (num_errors == 0 && num_checks > 0) begin
		$display("verification passed");
	end else begin
		$display("verification failed");
	end
	$finish;
endtask : print_verdict
initial begin
	#200000;
	num_errors++;
	print_verdict();
end
initial begin
	repeat (16) @(posedge hclk);
	hresetn <= 1'b1;
	t_reset();
	t_window();
	t_flush();
	t_complete();
	t_fpu();
	t_move();
	t_priv();
	print_verdict();
end
endmodule : wcm_exec_test
